/* mdfs_pkg.sv */
/*
 * Package for the motor driver fault and sleep controller: timing
 * constants, power state codes and the carrier structs.
 * Assumes a single 50 MHz clock domain.
 */
package mdfs_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 50;
    localparam int PULSE_MIN_US = 20;
    localparam int PULSE_MAX_US = 40;
    localparam int SHUT_MAX_US = 120;
    localparam int SLEEP_ENTRY_DELAY_US = 120;
    localparam int WAKE_DELAY_US = 1000;
    localparam int OVERCURRENT_QUALIFY_TIME_US = 2;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] PULSE_MIN_CYC = CNT_W'(PULSE_MIN_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] PULSE_MAX_CYC = CNT_W'(PULSE_MAX_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] SLEEP_ENTRY_CYC = CNT_W'(SLEEP_ENTRY_DELAY_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] WAKE_CYC = CNT_W'(WAKE_DELAY_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] OCP_CYC = CNT_W'(OVERCURRENT_QUALIFY_TIME_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

    // ==========================================================
    // Power states
    typedef enum logic [1:0] {
        PS_ASLEEP = 2'b00,
        PS_WAKING = 2'b01,
        PS_ACTIVE = 2'b10
    } mdfs_pwr_t;

    // Per-bridge control inputs and drive outputs
    typedef struct packed {
        logic in_one;
        logic in_two;
    } mdfs_bridge_in_t;

    typedef struct packed {
        logic out1;
        logic out2;
        logic oe1_n;
        logic oe2_n;
    } mdfs_bridge_out_t;

    // Analog monitor flags
    typedef struct packed {
        logic supply_low_lockout;
        logic pump_low_lockout;
        logic overtemp_hot;
        logic overtemp_cool;
    } mdfs_mon_t;
endpackage

/* mdfs_ocp_qual.sv */
/*
 * Overcurrent qualifier for one H-bridge: latches a trip once the
 * current limit has persisted longer than the qualification time.
 * Assumes the limit flag is synchronous to CLOCK.
 */
`timescale 1ns/1ps
`default_nettype none
module mdfs_ocp_qual (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic limit,
    input wire logic clear,
    // Status
    output logic trip
);
    typedef struct packed {
        logic [mdfs_pkg::CNT_W-1:0] cnt;
        logic trip;
    } mdfs_ocp_st_t;

    mdfs_ocp_st_t st;
    mdfs_ocp_st_t next_st;

    always_comb begin
        next_st = st;
        if (limit) begin
            if (st.cnt != mdfs_pkg::CNT_MAX) begin
                next_st.cnt = st.cnt + mdfs_pkg::CNT_ONE;
            end
        end else begin
            next_st.cnt = mdfs_pkg::CNT_ZERO;
        end
        // Clear first, so a new qualified trip in the same cycle wins
        if (clear) begin
            next_st.trip = 1'b0;
        end
        if (limit && st.cnt >= mdfs_pkg::OCP_CYC) begin
            next_st.trip = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign trip = st.trip;
endmodule
`default_nettype wire

/* mdfs_ctrl.sv */
/*
 * Fault protection and sleep/wake sequencing for a dual H-bridge
 * motor driver.
 * Assumes all inputs synchronous to CLOCK; analog comparators supply
 * the monitor flags; the pads resolve open-drain and tri-state pins.
 */
`timescale 1ns/1ps
`default_nettype none
module mdfs_ctrl (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // Sleep control from the external controller
    input wire logic SLEEP_IN_N,
    // Bridge control inputs, A then B
    input wire mdfs_pkg::mdfs_bridge_in_t BRIDGE_A_IN,
    input wire mdfs_pkg::mdfs_bridge_in_t BRIDGE_B_IN,
    // Analog monitors
    input wire mdfs_pkg::mdfs_mon_t MONITOR,
    input wire logic MOTOR_SUPPLY_PRESENT,
    input wire logic [1:0] OVERCURRENT_LIMIT,
    // Bridge drive
    output mdfs_pkg::mdfs_bridge_out_t BRIDGE_A_OUT,
    output mdfs_pkg::mdfs_bridge_out_t BRIDGE_B_OUT,
    // Power control
    output logic CHARGE_PUMP_EN,
    output logic LOGIC_LDO_EN,
    // Open-drain fault output, enable low while pulling low
    output logic FAULT_OUT_N,
    output logic FAULT_OE_N,
    // Status
    output logic ACTIVE
);
    typedef struct packed {
        mdfs_pkg::mdfs_pwr_t pwr;
        logic [mdfs_pkg::CNT_W-1:0] low_cnt;
        logic [mdfs_pkg::CNT_W-1:0] wake_cnt;
        logic sleep_prev_n;
        logic overtemp_trip;
        mdfs_pkg::mdfs_bridge_out_t a_out;
        mdfs_pkg::mdfs_bridge_out_t b_out;
        logic pump_en;
        logic ldo_en;
        logic fault_n;
    } mdfs_state_t;

    mdfs_state_t st;
    mdfs_state_t next_st;
    logic [1:0] ocp_trip;
    logic fault_clear;
    logic any_fault;
    logic bridges_ok;

    // Drive map shared by both bridges; disabled means both legs high-Z
    function automatic mdfs_pkg::mdfs_bridge_out_t drive(
        input mdfs_pkg::mdfs_bridge_in_t in_pins,
        input logic enable
    );
        mdfs_pkg::mdfs_bridge_out_t o;
        o.out1 = enable & in_pins.in_one;
        o.out2 = enable & in_pins.in_two;
        o.oe1_n = ~enable;
        o.oe2_n = ~enable;
        return o;
    endfunction

    // ==========================================================
    // Reset pulse decode
    // A low period above 20 us ending before the sleep-entry delay
    // clears latched faults; above that the device is asleep anyway
    // and the clear still applies (40-120 us case resolved as a clear; the device stays awake).
    assign fault_clear = SLEEP_IN_N && !st.sleep_prev_n
        && st.low_cnt > mdfs_pkg::PULSE_MIN_CYC;

    // Per-bridge overcurrent qualifiers, cleared only by the pulse
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ocp
            mdfs_ocp_qual u_ocp (
                .clk(CLOCK),
                .rst(SYS_RST),
                .limit(OVERCURRENT_LIMIT[gi]),
                .clear(fault_clear),
                .trip(ocp_trip[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Fault aggregation
    assign any_fault = MONITOR.supply_low_lockout
        | MONITOR.pump_low_lockout
        | st.overtemp_trip
        | (|ocp_trip);

    // Global bridge permission; overcurrent gates per bridge below
    assign bridges_ok = (st.pwr == mdfs_pkg::PS_ACTIVE)
        && !MONITOR.supply_low_lockout
        && !MONITOR.pump_low_lockout
        && !st.overtemp_trip;

    always_comb begin
        next_st = st;
        next_st.sleep_prev_n = SLEEP_IN_N;

        // Time the low period in clock cycles (20 ns resolution)
        if (!SLEEP_IN_N) begin
            if (st.low_cnt != mdfs_pkg::CNT_MAX) begin
                next_st.low_cnt = st.low_cnt + mdfs_pkg::CNT_ONE;
            end
        end else begin
            next_st.low_cnt = mdfs_pkg::CNT_ZERO;
        end

        // Over-temperature latch: set wins, clear needs hysteresis cool
        if (fault_clear && MONITOR.overtemp_cool) begin
            next_st.overtemp_trip = 1'b0;
        end
        if (MONITOR.overtemp_hot) begin
            next_st.overtemp_trip = 1'b1;
        end

        unique case (st.pwr)
            mdfs_pkg::PS_ASLEEP: begin
                next_st.wake_cnt = mdfs_pkg::CNT_ZERO;
                if (SLEEP_IN_N && MOTOR_SUPPLY_PRESENT) begin
                    next_st.pwr = mdfs_pkg::PS_WAKING;
                end
            end
            mdfs_pkg::PS_WAKING: begin
                if (!SLEEP_IN_N || !MOTOR_SUPPLY_PRESENT) begin
                    next_st.pwr = mdfs_pkg::PS_ASLEEP;
                end else if (st.wake_cnt >= mdfs_pkg::WAKE_CYC
                        && !MONITOR.supply_low_lockout) begin
                    next_st.pwr = mdfs_pkg::PS_ACTIVE;
                end else if (st.wake_cnt != mdfs_pkg::CNT_MAX) begin
                    // Saturate so a long lockout during wake cannot wrap the count
                    next_st.wake_cnt = st.wake_cnt + mdfs_pkg::CNT_ONE;
                end
            end
            mdfs_pkg::PS_ACTIVE: begin
                // A short reset pulse keeps the device awake
                if (!MOTOR_SUPPLY_PRESENT) begin
                    next_st.pwr = mdfs_pkg::PS_ASLEEP;
                end else if (!SLEEP_IN_N
                        && st.low_cnt >= mdfs_pkg::SLEEP_ENTRY_CYC) begin
                    next_st.pwr = mdfs_pkg::PS_ASLEEP;
                end
            end
            default: begin
                next_st.pwr = mdfs_pkg::PS_ASLEEP;
            end
        endcase

        // Bridge outputs go high-Z whenever the sleep input is low
        next_st.a_out = drive(BRIDGE_A_IN,
            bridges_ok && SLEEP_IN_N && !ocp_trip[0]);
        next_st.b_out = drive(BRIDGE_B_IN,
            bridges_ok && SLEEP_IN_N && !ocp_trip[1]);

        // Pump runs through pump undervoltage and overcurrent
        next_st.pump_en = (st.pwr != mdfs_pkg::PS_ASLEEP)
            && !MONITOR.supply_low_lockout
            && !st.overtemp_trip;
        next_st.ldo_en = (st.pwr != mdfs_pkg::PS_ASLEEP)
            && MOTOR_SUPPLY_PRESENT;
        next_st.fault_n = ~any_fault;
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st.pwr <= mdfs_pkg::PS_ASLEEP;
            st.low_cnt <= mdfs_pkg::CNT_ZERO;
            st.wake_cnt <= mdfs_pkg::CNT_ZERO;
            st.sleep_prev_n <= 1'b0;
            st.overtemp_trip <= 1'b0;
            st.a_out <= 4'h3;
            st.b_out <= 4'h3;
            st.pump_en <= 1'b0;
            st.ldo_en <= 1'b0;
            st.fault_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign BRIDGE_A_OUT = st.a_out;
    assign BRIDGE_B_OUT = st.b_out;
    assign CHARGE_PUMP_EN = st.pump_en;
    assign LOGIC_LDO_EN = st.ldo_en;
    // Open drain: only ever drive low, release otherwise
    assign FAULT_OUT_N = 1'b0;
    assign FAULT_OE_N = st.fault_n;
    assign ACTIVE = (st.pwr == mdfs_pkg::PS_ACTIVE);
endmodule
`default_nettype wire

/* mdfs_ctrl_asserts.sv */
/* Checker for the fault and sleep controller: watches the top ports only.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module mdfs_ctrl_asserts (
    // Clock, reset and inputs
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic SLEEP_IN_N,
    input wire mdfs_pkg::mdfs_mon_t MONITOR,
    input wire logic MOTOR_SUPPLY_PRESENT,
    input wire logic [1:0] OVERCURRENT_LIMIT,
    // Outputs
    input wire mdfs_pkg::mdfs_bridge_out_t BRIDGE_A_OUT,
    input wire mdfs_pkg::mdfs_bridge_out_t BRIDGE_B_OUT,
    input wire logic CHARGE_PUMP_EN,
    input wire logic LOGIC_LDO_EN,
    input wire logic FAULT_OUT_N,
    input wire logic FAULT_OE_N,
    input wire logic ACTIVE
);
    logic [15:0] slc;
    logic [15:0] occ;
    logic hza;
    logic hzb;
    assign hza = BRIDGE_A_OUT.oe1_n & BRIDGE_A_OUT.oe2_n;
    assign hzb = BRIDGE_B_OUT.oe1_n & BRIDGE_B_OUT.oe2_n;
    // Saturating run lengths of sleep low and of the bridge A current limit
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            slc <= 16'h0000;
            occ <= 16'h0000;
        end else begin
            slc <= SLEEP_IN_N ? 16'h0000 : slc + {15'h0000, slc != 16'hFFFF};
            occ <= !OVERCURRENT_LIMIT[0] ? 16'h0000 : occ + {15'h0000, occ != 16'hFFFF};
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    AST_OPEN_DRAIN: assert property (FAULT_OUT_N == 1'h0) else $error("fault data not low");
    AST_SLEEP_HIZ: assert property (!SLEEP_IN_N |=> hza && hzb) else $error("bridge driven in sleep");
    AST_SUPPLY_LOW: assert property (MONITOR.supply_low_lockout [*3] |-> hza && hzb && !FAULT_OE_N && !CHARGE_PUMP_EN) else $error("supply lockout");
    AST_PUMP_LOW: assert property (MONITOR.pump_low_lockout [*3] |-> hza && hzb && !FAULT_OE_N) else $error("pump lockout");
    AST_OVERTEMP: assert property (MONITOR.overtemp_hot [*3] |-> hza && hzb && !FAULT_OE_N) else $error("overtemp");
    AST_OC_TRIP: assert property (occ > 16'h006C |-> hza && !FAULT_OE_N) else $error("overcurrent trip");
    AST_IDLE_HIZ: assert property (!ACTIVE && !$past(ACTIVE) |-> hza && hzb) else $error("driven while inactive");
    AST_SLEEP_LATE: assert property (ACTIVE && !SLEEP_IN_N && MOTOR_SUPPLY_PRESENT && slc < 16'h1740 |=> ACTIVE || !MOTOR_SUPPLY_PRESENT) else $error("early sleep");
    AST_SLEEP_OFF: assert property (slc > 16'h1790 |-> !ACTIVE && !CHARGE_PUMP_EN && !LOGIC_LDO_EN) else $error("not asleep");
    AST_NO_SUPPLY: assert property (!MOTOR_SUPPLY_PRESENT [*3] |-> !LOGIC_LDO_EN && !ACTIVE) else $error("regulator on");
endmodule
bind mdfs_ctrl mdfs_ctrl_asserts u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .SLEEP_IN_N(SLEEP_IN_N),
    .MONITOR(MONITOR), .MOTOR_SUPPLY_PRESENT(MOTOR_SUPPLY_PRESENT),
    .OVERCURRENT_LIMIT(OVERCURRENT_LIMIT), .BRIDGE_A_OUT(BRIDGE_A_OUT),
    .BRIDGE_B_OUT(BRIDGE_B_OUT), .CHARGE_PUMP_EN(CHARGE_PUMP_EN), .LOGIC_LDO_EN(LOGIC_LDO_EN),
    .FAULT_OUT_N(FAULT_OUT_N), .FAULT_OE_N(FAULT_OE_N), .ACTIVE(ACTIVE));
`default_nettype wire

/* mdfs_ctl_model.sv */
/* Behavioural motion controller: drives the sleep line and both bridge input pairs.
   Assumes the bench commands it from the falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module mdfs_ctl_model (
    // Clock and commands
    input wire logic clk,
    input wire logic run,
    input wire logic go,
    input wire logic [15:0] len,
    input wire logic [3:0] drive,
    // Pins toward the device, and the busy flag back to the bench
    output logic sleep_n,
    output mdfs_pkg::mdfs_bridge_in_t a,
    output mdfs_pkg::mdfs_bridge_in_t b,
    output logic busy
);
    logic [15:0] cnt;
    initial begin
        cnt = 16'h0000;
        sleep_n = 1'h0;
        a = 2'h0;
        b = 2'h0;
    end
    assign busy = go | (cnt != 16'h0000);
    // Sleep line is always driven here, never strapped to the regulator output
    always @(negedge clk) begin
        cnt <= go ? len : cnt - {15'h0000, cnt != 16'h0000};
        sleep_n <= run & ~go & (cnt <= 16'h0001);
        a <= drive[3:2];
        b <= drive[1:0];
    end
endmodule
`default_nettype wire

/* testbench.sv */
/* Self-checking bench for the fault and sleep controller.
   Assumes the checker is bound to the design and the controller model drives its pins. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [3:0] d;
        mdfs_pkg::mdfs_bridge_out_t ea;
        mdfs_pkg::mdfs_bridge_out_t eb;
    } mdfs_row_t;
    logic clk = 1'h0, rst = 1'h1, run = 1'h0, go = 1'h0, msp = 1'h1, busy, sleep_n;
    logic [15:0] len = 16'h0000;
    logic [3:0] drive = 4'h0;
    logic [1:0] ocl = 2'h0;
    mdfs_pkg::mdfs_mon_t mon = 4'h0;
    mdfs_pkg::mdfs_bridge_in_t bin_a, bin_b;
    mdfs_pkg::mdfs_bridge_out_t oa, ob;
    logic pump, ldo, fault_n, fault_oe_n, active;
    int errors = 0, n_checks = 0, i;
    time t0;
    mdfs_row_t rows [4] = '{{4'h0, 4'h0, 4'h0}, {4'h6, 4'h4, 4'h8}, {4'h9, 4'h8, 4'h4},
        {4'hF, 4'hC, 4'hC}};
    always #10 clk = ~clk;
    mdfs_ctl_model CTL (.clk(clk), .run(run), .go(go), .len(len), .drive(drive),
        .sleep_n(sleep_n), .a(bin_a), .b(bin_b), .busy(busy));
    mdfs_ctrl DUT (.CLOCK(clk), .SYS_RST(rst), .SLEEP_IN_N(sleep_n), .BRIDGE_A_IN(bin_a),
        .BRIDGE_B_IN(bin_b), .MONITOR(mon), .MOTOR_SUPPLY_PRESENT(msp),
        .OVERCURRENT_LIMIT(ocl), .BRIDGE_A_OUT(oa), .BRIDGE_B_OUT(ob), .CHARGE_PUMP_EN(pump),
        .LOGIC_LDO_EN(ldo), .FAULT_OUT_N(fault_n), .FAULT_OE_N(fault_oe_n), .ACTIVE(active));
    function automatic logic hz(input mdfs_pkg::mdfs_bridge_out_t x);
        return x.oe1_n & x.oe2_n;
    endfunction
    task automatic chk_fl(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_br(input mdfs_pkg::mdfs_bridge_out_t got, input mdfs_pkg::mdfs_bridge_out_t exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t bridge %b expected %b", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic bail(input int k, input int lim);
        if (k >= lim) begin
            errors++;
            $display("FAIL t=%0t wait ran out", $time);
            give_verdict();
        end
    endtask
    task automatic wait_act;
        int k;
        for (k = 0; k < 60000 && active !== 1'h1; k++) step(1);
        bail(k, 60000);
    endtask
    // Low pulse on the sleep line; width in clock cycles
    task automatic pulse(input logic [15:0] w);
        int k;
        go <= 1'h1;
        len <= w;
        step(1);
        go <= 1'h0;
        for (k = 0; k < 8000 && busy; k++) step(1);
        bail(k, 8000);
        step(5);
    endtask
    task automatic trip_a;
        ocl <= 2'h1;
        step(90);
        chk_br(oa, 4'h8);
        step(20);
        chk_fl(hz(oa) & ~hz(ob) & ~fault_oe_n & pump, 1'h1);
        ocl <= 2'h0;
        step(10);
        chk_fl(hz(oa) | fault_oe_n, 1'h1);
        chk_fl(fault_oe_n, 1'h0);
    endtask
    initial begin
        // Whole run stays well under the cycle budget
        #(90000 * 20);
        errors++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk) rst <= 1'h0;
        step(1);
        chk_fl(hz(oa) & hz(ob) & fault_oe_n, 1'h1);
        chk_fl(pump | ldo | active, 1'h0);
        run <= 1'h1;
        t0 = $time;
        wait_act();
        chk_fl(pump & ldo, 1'h1);
        chk_fl(($time - t0) >= mdfs_pkg::WAKE_DELAY_US * 1000, 1'h1);
        for (i = 0; i < 4; i++) begin
            drive <= rows[i].d;
            step(3);
            chk_br(oa, rows[i].ea);
            chk_br(ob, rows[i].eb);
        end
        drive <= 4'h9;
        // ==========================================================
        // Self-recovering lockouts: supply, then pump rail
        for (i = 0; i < 2; i++) begin
            mon <= (i == 0) ? 4'h8 : 4'h4;
            step(4);
            chk_fl(hz(oa) & hz(ob) & ~fault_oe_n, 1'h1);
            chk_fl(pump, i[0]);
            mon <= 4'h0;
            wait_act();
            step(4);
            chk_fl(fault_oe_n, 1'h1);
            chk_br(oa, 4'h8);
        end
        // ==========================================================
        // Latched overcurrent; a too-short pulse must not clear it
        trip_a();
        pulse(16'h01F4);
        chk_fl(fault_oe_n, 1'h0);
        pulse(16'h05DC);
        chk_fl(fault_oe_n & active & pump, 1'h1);
        chk_br(oa, 4'h8);
        // ==========================================================
        // Overtemp needs cooling before a pulse clears it
        mon <= 4'h2;
        step(4);
        chk_fl(hz(oa) & hz(ob) & ~fault_oe_n, 1'h1);
        mon <= 4'h1;
        step(5);
        chk_fl(fault_oe_n, 1'h0);
        pulse(16'h05DC);
        chk_fl(fault_oe_n, 1'h1);
        chk_br(ob, 4'h4);
        mon <= 4'h0;
        trip_a();
        pulse(16'h0BB8);
        chk_fl(fault_oe_n, 1'h1);
        // ==========================================================
        // Sleep entry, then loss of the motor supply
        run <= 1'h0;
        step(3);
        chk_fl(hz(oa) & hz(ob), 1'h1);
        step(5800);
        chk_fl(active, 1'h1);
        step(400);
        chk_fl(active | pump | ldo, 1'h0);
        msp <= 1'h0;
        step(4);
        chk_fl(ldo, 1'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
